/* File: inc/fbpdm_pkg.sv */
// package: constants for the fieldbus process data mapper
package fbpdm_pkg;
  // cyclic assembly geometry
  localparam int unsigned OUT_BYTES     = 16;
  localparam int unsigned OUT_WORDS16   = 8;
  localparam int unsigned IN_WORDS32    = 5;
  localparam int unsigned NUM_READ_SEL  = 4;
  localparam logic [15:0] ASM_OUT_ID    = 16'h0096;
  localparam logic [15:0] ASM_IN_ID     = 16'h0064;

  // 16-bit member index of each output field
  localparam int unsigned OW_CMD        = 0;
  localparam int unsigned OW_WR_NUM     = 1;
  localparam int unsigned OW_WR_VAL_LO  = 2;
  localparam int unsigned OW_WR_VAL_HI  = 3;
  localparam int unsigned OW_RD_NUM0    = 4;

  // command word bits
  localparam int unsigned CMD_START     = 0;
  localparam int unsigned CMD_FREEZE    = 1;
  localparam int unsigned CMD_RESET     = 2;
  localparam int unsigned CMD_EXT_TRIP  = 3;
  localparam int unsigned CMD_NET_CTRL  = 4;
  localparam logic [15:0] CMD_USED_MASK = 16'h001F;

  // status word bits
  localparam int unsigned ST_TRIP       = 0;
  localparam int unsigned ST_RUNNING    = 1;
  localparam int unsigned ST_END_START  = 2;
  localparam int unsigned ST_CUR_LIMIT  = 3;
  localparam int unsigned ST_EFF_MODE   = 4;
  localparam int unsigned ST_STOPPING   = 5;
  localparam int unsigned ST_NET_ACTIVE = 6;
  localparam int unsigned ST_FLAGS      = 7;
  localparam int unsigned ST_CODE_LSB   = 16;

  // explicit addressing
  localparam logic [7:0]  EXP_CLASS       = 8'hA2;
  localparam logic [7:0]  EXP_ATTR        = 8'h05;
  localparam logic [7:0]  INST_CMD        = 8'h02;
  localparam logic [7:0]  INST_STATUS     = 8'h03;
  localparam logic [7:0]  INST_WR_NUM     = 8'h64;
  localparam logic [7:0]  INST_WR_VAL     = 8'h65;
  localparam logic [7:0]  INST_RD_NUM0    = 8'h66;
  localparam logic [7:0]  INST_SEL_VAL0   = 8'h6A;

  localparam logic [15:0] NUM_NONE      = 16'h0000;
  localparam logic [31:0] VAL_ZERO      = 32'h0000_0000;
  localparam logic [15:0] CMD_RESET_VAL = 16'h0000;

  // explicit answer codes
  typedef enum logic [1:0] {
    FBPDM_ANS_OK       = 2'b00,
    FBPDM_ANS_BAD_PATH = 2'b01,
    FBPDM_ANS_READ_ONLY= 2'b10
  } fbpdm_ans_t;
endpackage : fbpdm_pkg

/* File: logic/fbpdm_mapper.sv */
// top: cyclic and explicit process data mapper for the soft starter
// Operation
// - Command word bits 0 to 4 are start, freeze ramp, fault reset, external trip and network control.
// - Command bits 0 to 3 take effect only while the network-control bit is set.
// - Output word 1 names the parameter that receives the 32-bit value of words 2 and 3.
// - A write target number of zero performs no parameter write.
// - A parameter narrower than 32 bits receives only the low part of the write value.
// - Output words 4 to 7 are four independent read selection numbers.
// - A read selection number of zero returns the value zero.
// - The input assembly is five 32-bit words, status first then four selected values.
// - Status bits 0 to 6 are trip, running, end of start, current limit, efficiency mode, stopping, net active.
// - While tripped the status upper half carries the trip code.
// - Selected values are right aligned and wider values keep their low 32 bits.
// - Selected values appear in input words 2 to 5 in the order of the read selections.
// - Command word and status are explicit attributes at class A2 instance 2 and 3, attribute 5.
// - Instances 100 to 105 hold the writable selections and 106 to 109 the read-only values.
`timescale 1ns/1ns
`default_nettype none
module fbpdm_mapper (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // cyclic output assembly, one 16-byte frame per strobe
  input  wire logic         cyc_valid_i,
  input  wire logic [127:0] cyc_data_i,
  // cyclic input assembly, five words, word 1 in the low bits
  output var  logic [159:0] cyc_in_o,
  // explicit messaging
  input  wire logic         exp_valid_i,
  input  wire logic         exp_write_i,
  input  wire logic [7:0]   exp_class_i,
  input  wire logic [7:0]   exp_inst_i,
  input  wire logic [7:0]   exp_attr_i,
  input  wire logic [31:0]  exp_wdata_i,
  output var  logic         exp_done_o,
  output var  logic [1:0]   exp_status_o,
  output var  logic [31:0]  exp_rdata_o,
  // starter commands
  output var  logic         cmd_start_o,
  output var  logic         cmd_freeze_o,
  output var  logic         cmd_reset_o,
  output var  logic         cmd_ext_trip_o,
  output var  logic         cmd_net_ctrl_o,
  // starter state
  input  wire logic         st_trip_i,
  input  wire logic         st_running_i,
  input  wire logic         st_end_start_i,
  input  wire logic         st_cur_limit_i,
  input  wire logic         st_eff_mode_i,
  input  wire logic         st_stopping_i,
  input  wire logic [15:0]  st_trip_code_i,
  // parameter store write port
  output var  logic         par_wr_o,
  output var  logic [15:0]  par_wr_num_o,
  output var  logic [31:0]  par_wr_data_o,
  input  wire logic         par_wr_narrow_i,
  // parameter store read ports, one per slot
  output logic [63:0]       par_rd_num_o,
  input  wire logic [255:0] par_rd_data_i
);
  localparam int unsigned NS = fbpdm_pkg::NUM_READ_SEL;

  logic [15:0] command_word;
  logic [15:0] write_target_number;
  logic [31:0] write_value;
  logic [15:0] read_num [NS];
  logic [31:0] sel_val  [NS];
  logic        wr_pending;

  // cyclic field extraction
  wire logic [15:0] cyc_cmd;
  wire logic [15:0] cyc_wr_num;
  wire logic [31:0] cyc_wr_val;
  assign cyc_cmd    = cyc_data_i[16*fbpdm_pkg::OW_CMD +: 16];
  assign cyc_wr_num = cyc_data_i[16*fbpdm_pkg::OW_WR_NUM +: 16];
  assign cyc_wr_val = {cyc_data_i[16*fbpdm_pkg::OW_WR_VAL_HI +: 16],
                       cyc_data_i[16*fbpdm_pkg::OW_WR_VAL_LO +: 16]};

  // explicit decode
  wire logic exp_path_ok;
  wire logic exp_is_cmd;
  wire logic exp_is_status;
  wire logic exp_is_wr_num;
  wire logic exp_is_wr_val;
  wire logic exp_is_rd_num;
  wire logic exp_is_sel;
  wire logic [1:0] exp_rd_idx;
  wire logic [1:0] exp_sel_idx;
  wire logic [7:0] exp_rd_off;
  wire logic [7:0] exp_sel_off;
  assign exp_path_ok   = (exp_class_i == fbpdm_pkg::EXP_CLASS) && (exp_attr_i == fbpdm_pkg::EXP_ATTR);
  assign exp_rd_off    = exp_inst_i - fbpdm_pkg::INST_RD_NUM0;
  assign exp_sel_off   = exp_inst_i - fbpdm_pkg::INST_SEL_VAL0;
  assign exp_rd_idx    = exp_rd_off[1:0];
  assign exp_sel_idx   = exp_sel_off[1:0];
  assign exp_is_cmd    = exp_path_ok && (exp_inst_i == fbpdm_pkg::INST_CMD);
  assign exp_is_status = exp_path_ok && (exp_inst_i == fbpdm_pkg::INST_STATUS);
  assign exp_is_wr_num = exp_path_ok && (exp_inst_i == fbpdm_pkg::INST_WR_NUM);
  assign exp_is_wr_val = exp_path_ok && (exp_inst_i == fbpdm_pkg::INST_WR_VAL);
  assign exp_is_rd_num = exp_path_ok && (exp_inst_i >= fbpdm_pkg::INST_RD_NUM0)
                         && (exp_inst_i < fbpdm_pkg::INST_SEL_VAL0);
  assign exp_is_sel    = exp_path_ok && (exp_inst_i >= fbpdm_pkg::INST_SEL_VAL0)
                         && (exp_rd_off < 8'(2*NS));
  wire logic exp_hit;
  wire logic exp_ro;
  wire logic exp_wr_ok;
  assign exp_hit   = exp_is_cmd | exp_is_status | exp_is_wr_num | exp_is_wr_val | exp_is_rd_num | exp_is_sel;
  assign exp_ro    = exp_is_status | exp_is_sel;
  assign exp_wr_ok = exp_valid_i && exp_write_i && exp_hit && !exp_ro;

  // command decode: bits 0..3 gated by network control
  wire logic net_ctrl;
  assign net_ctrl = command_word[fbpdm_pkg::CMD_NET_CTRL];

  // status word
  wire logic [15:0] status_flags;
  wire logic [31:0] state_report;
  assign status_flags = 16'({net_ctrl, st_stopping_i, st_eff_mode_i,
                             st_cur_limit_i, st_end_start_i,
                             st_running_i, st_trip_i});
  assign state_report = {st_trip_i ? st_trip_code_i : fbpdm_pkg::NUM_NONE, status_flags};

  // parameter read slots
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_slot
      assign par_rd_num_o[16*g +: 16] = read_num[g];
      fbpdm_read_slot u_slot (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .num_i      (read_num[g]),
        .par_data_i (par_rd_data_i[64*g +: 64]),
        .value_o    (sel_val[g])
      );
      assign cyc_in_o[32*(g+1) +: 32] = sel_val[g];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          read_num[g] <= fbpdm_pkg::NUM_NONE;
        end else if (ce_i) begin
          if (cyc_valid_i) begin
            read_num[g] <= cyc_data_i[16*(fbpdm_pkg::OW_RD_NUM0+g) +: 16];
          end else if (exp_wr_ok && exp_is_rd_num && exp_rd_idx == 2'(g)) begin
            read_num[g] <= exp_wdata_i[15:0];
          end
        end
      end
    end
  endgenerate

  // status word registered into the input assembly
  // separate register: the output vector has one kind of driver only
  logic [31:0] status_q;
  assign cyc_in_o[31:0] = status_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= fbpdm_pkg::VAL_ZERO;
    end else if (ce_i) begin
      status_q <= state_report;
    end
  end

  // assembly fields written by cyclic frames or explicit writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command_word        <= fbpdm_pkg::CMD_RESET_VAL;
      write_target_number <= fbpdm_pkg::NUM_NONE;
      write_value         <= fbpdm_pkg::VAL_ZERO;
      wr_pending          <= 1'b0;
    end else if (ce_i) begin
      wr_pending <= 1'b0;
      if (cyc_valid_i) begin
        command_word        <= cyc_cmd & fbpdm_pkg::CMD_USED_MASK;
        write_target_number <= cyc_wr_num;
        write_value         <= cyc_wr_val;
        wr_pending          <= 1'b1;
      end else if (exp_wr_ok) begin
        if (exp_is_cmd) begin
          command_word <= exp_wdata_i[15:0] & fbpdm_pkg::CMD_USED_MASK;
        end
        if (exp_is_wr_num) begin
          write_target_number <= exp_wdata_i[15:0];
        end
        if (exp_is_wr_val) begin
          write_value <= exp_wdata_i;
        end
        wr_pending <= exp_is_wr_num | exp_is_wr_val;
      end
    end
  end

  // command outputs and parameter write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_start_o    <= 1'b0;
      cmd_freeze_o   <= 1'b0;
      cmd_reset_o    <= 1'b0;
      cmd_ext_trip_o <= 1'b0;
      cmd_net_ctrl_o <= 1'b0;
      par_wr_o       <= 1'b0;
      par_wr_num_o   <= fbpdm_pkg::NUM_NONE;
      par_wr_data_o  <= fbpdm_pkg::VAL_ZERO;
    end else if (ce_i) begin
      cmd_start_o    <= net_ctrl & command_word[fbpdm_pkg::CMD_START];
      cmd_freeze_o   <= net_ctrl & command_word[fbpdm_pkg::CMD_FREEZE];
      cmd_reset_o    <= net_ctrl & command_word[fbpdm_pkg::CMD_RESET];
      cmd_ext_trip_o <= net_ctrl & command_word[fbpdm_pkg::CMD_EXT_TRIP];
      cmd_net_ctrl_o <= net_ctrl;
      // zero target means no assignment
      par_wr_o       <= wr_pending && (write_target_number != fbpdm_pkg::NUM_NONE);
      par_wr_num_o   <= write_target_number;
      // narrow targets keep only the low half
      par_wr_data_o  <= par_wr_narrow_i ? {16'h0000, write_value[15:0]} : write_value;
    end
  end

  // explicit answers, one cycle after the request
  wire logic [31:0] exp_read_mux;
  assign exp_read_mux = exp_is_cmd    ? {16'h0000, command_word} :
                        exp_is_status ? state_report :
                        exp_is_wr_num ? {16'h0000, write_target_number} :
                        exp_is_wr_val ? write_value :
                        exp_is_rd_num ? {16'h0000, read_num[exp_rd_idx]} :
                        exp_is_sel    ? sel_val[exp_sel_idx] : fbpdm_pkg::VAL_ZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exp_done_o   <= 1'b0;
      exp_status_o <= fbpdm_pkg::FBPDM_ANS_OK;
      exp_rdata_o  <= fbpdm_pkg::VAL_ZERO;
    end else if (ce_i) begin
      exp_done_o <= exp_valid_i;
      if (exp_valid_i) begin
        // read-only fields refuse writes and change nothing
        exp_status_o <= !exp_hit ? fbpdm_pkg::FBPDM_ANS_BAD_PATH :
                        (exp_write_i && exp_ro) ? fbpdm_pkg::FBPDM_ANS_READ_ONLY : fbpdm_pkg::FBPDM_ANS_OK;
        exp_rdata_o  <= exp_write_i ? fbpdm_pkg::VAL_ZERO : exp_read_mux;
      end
    end
  end
endmodule : fbpdm_mapper
`default_nettype wire

/* File: logic/fbpdm_read_slot.sv */
// one read-select slot: selection number to returned value
`timescale 1ns/1ns
`default_nettype none
module fbpdm_read_slot (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [15:0] num_i,
  input  wire logic [63:0] par_data_i,
  output var  logic [31:0] value_o
);
  wire logic [31:0] next_value;

  // zero number means no parameter; wide values keep low 32 bits
  assign next_value = (num_i == fbpdm_pkg::NUM_NONE) ? fbpdm_pkg::VAL_ZERO
                                                     : par_data_i[31:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= fbpdm_pkg::VAL_ZERO;
    end else if (ce_i) begin
      value_o <= next_value;
    end
  end
endmodule : fbpdm_read_slot
`default_nettype wire

/* File: verification/fbpdm_mapper_properties.sv */
// port-level properties of the process data mapper
`timescale 1ns/1ns
`default_nettype none
module fbpdm_mapper_props (
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         ce_i,
  input wire logic         cyc_valid_i,
  input wire logic [159:0] cyc_in_o,
  input wire logic         exp_valid_i,
  input wire logic         exp_write_i,
  input wire logic [7:0]   exp_class_i,
  input wire logic [7:0]   exp_inst_i,
  input wire logic [7:0]   exp_attr_i,
  input wire logic         exp_done_o,
  input wire logic [1:0]   exp_status_o,
  input wire logic         cmd_start_o,
  input wire logic         cmd_freeze_o,
  input wire logic         cmd_reset_o,
  input wire logic         cmd_ext_trip_o,
  input wire logic         cmd_net_ctrl_o,
  input wire logic         st_trip_i,
  input wire logic [15:0]  st_trip_code_i,
  input wire logic         par_wr_o,
  input wire logic [15:0]  par_wr_num_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_start_gated: assert property (cmd_start_o |-> cmd_net_ctrl_o)
    else $error("start without net control");
  a_cmd_gated: assert property ((cmd_freeze_o | cmd_reset_o | cmd_ext_trip_o) |-> cmd_net_ctrl_o)
    else $error("command without net control");
  a_status_rsvd: assert property (cyc_in_o[15:7] == 9'h000)
    else $error("reserved status bits set");
  a_code_idle: assert property (!cyc_in_o[0] |-> cyc_in_o[31:16] == 16'h0000)
    else $error("trip code without trip");
  a_trip_code: assert property ($past(!rst_i) && $past(ce_i) && $past(st_trip_i)
    |-> cyc_in_o[0] && cyc_in_o[31:16] == $past(st_trip_code_i))
    else $error("trip code not reported");
  a_wr_nonzero: assert property (par_wr_o |-> par_wr_num_o != 16'h0000)
    else $error("write to number zero");
  a_wr_cause: assert property (par_wr_o |-> $past(cyc_valid_i, 2) || $past(exp_valid_i & exp_write_i, 2))
    else $error("parameter write without request");
  a_done_next: assert property (exp_valid_i && ce_i |=> exp_done_o)
    else $error("explicit request unanswered");
  a_ro_status: assert property (exp_valid_i && ce_i && exp_write_i && exp_class_i == fbpdm_pkg::EXP_CLASS
    && exp_attr_i == fbpdm_pkg::EXP_ATTR && exp_inst_i == fbpdm_pkg::INST_STATUS
    |=> exp_status_o == fbpdm_pkg::FBPDM_ANS_READ_ONLY)
    else $error("status write not refused");
  a_ro_values: assert property (exp_valid_i && ce_i && exp_write_i && exp_class_i == fbpdm_pkg::EXP_CLASS
    && exp_attr_i == fbpdm_pkg::EXP_ATTR && exp_inst_i >= fbpdm_pkg::INST_SEL_VAL0 && exp_inst_i <= 8'h6D
    |=> exp_status_o == fbpdm_pkg::FBPDM_ANS_READ_ONLY)
    else $error("value write not refused");
  a_bad_class: assert property (exp_valid_i && ce_i && exp_class_i != fbpdm_pkg::EXP_CLASS
    |=> exp_status_o == fbpdm_pkg::FBPDM_ANS_BAD_PATH)
    else $error("bad class accepted");
endmodule : fbpdm_mapper_props
bind fbpdm_mapper fbpdm_mapper_props u_props (.clk_i, .rst_i, .ce_i, .cyc_valid_i, .cyc_in_o, .exp_valid_i,
  .exp_write_i, .exp_class_i, .exp_inst_i, .exp_attr_i, .exp_done_o, .exp_status_o, .cmd_start_o, .cmd_freeze_o,
  .cmd_reset_o, .cmd_ext_trip_o, .cmd_net_ctrl_o, .st_trip_i, .st_trip_code_i, .par_wr_o, .par_wr_num_o);
`default_nettype wire

/* File: verification/fbpdm_mapper_test.sv */
// self-checking bench for the process data mapper
`timescale 1ns/1ns
`default_nettype none
module fbpdm_mapper_test;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         ce_i = 1'b1;
  logic         cyc_valid_i = 1'b0;
  logic         exp_valid_i = 1'b0;
  logic         exp_write_i = 1'b0;
  logic         par_wr_narrow_i = 1'b0;
  logic [127:0] cyc_data_i = '0;
  logic [7:0]   exp_class_i = 8'h00, exp_inst_i = 8'h00, exp_attr_i = 8'h00;
  logic [31:0]  exp_wdata_i = 32'h0000_0000;
  logic [5:0]   st = 6'h00;
  logic [15:0]  code = 16'h0000;
  logic [159:0] cyc_in_o;
  logic [255:0] par_rd_data_i;
  logic [63:0]  par_rd_num_o;
  logic [31:0]  exp_rdata_o, par_wr_data_o;
  logic [15:0]  par_wr_num_o;
  logic [1:0]   exp_status_o;
  logic         exp_done_o, par_wr_o, cmd_start_o, cmd_freeze_o, cmd_reset_o, cmd_ext_trip_o, cmd_net_ctrl_o;
  int           bad_count = 0;
  int           n_tests = 0;

  fbpdm_mapper dut (.clk_i, .rst_i, .ce_i, .cyc_valid_i, .cyc_data_i, .cyc_in_o, .exp_valid_i, .exp_write_i,
    .exp_class_i, .exp_inst_i, .exp_attr_i, .exp_wdata_i, .exp_done_o, .exp_status_o, .exp_rdata_o, .cmd_start_o,
    .cmd_freeze_o, .cmd_reset_o, .cmd_ext_trip_o, .cmd_net_ctrl_o, .st_trip_i(st[0]), .st_running_i(st[1]),
    .st_end_start_i(st[2]), .st_cur_limit_i(st[3]), .st_eff_mode_i(st[4]), .st_stopping_i(st[5]),
    .st_trip_code_i(code), .par_wr_o, .par_wr_num_o, .par_wr_data_o, .par_wr_narrow_i, .par_rd_num_o,
    .par_rd_data_i);
  fbpdm_param_store u_store (.num_i(par_rd_num_o), .data_o(par_rd_data_i));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // one output frame; returns once its results are visible
  task automatic frame(input logic [15:0] c, input logic [15:0] w, input logic [31:0] v, input logic [63:0] r);
    @(posedge clk_i);
    cyc_data_i  <= {r, v[31:16], v[15:0], w, c};
    cyc_valid_i <= 1'b1;
    @(posedge clk_i);
    cyc_valid_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : frame

  // one explicit access, answer one cycle after it is taken
  task automatic acc(input logic wr, input logic [7:0] cls, input logic [7:0] inst, input logic [31:0] wd,
                     input logic [1:0] est);
    @(posedge clk_i);
    {exp_write_i, exp_class_i, exp_inst_i, exp_wdata_i} <= {wr, cls, inst, wd};
    exp_attr_i  <= fbpdm_pkg::EXP_ATTR;
    exp_valid_i <= 1'b1;
    @(posedge clk_i);
    exp_valid_i <= 1'b0;
    #1;
    chk(32'({exp_done_o, exp_status_o}), 32'({1'b1, est}));
  endtask : acc

  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    results();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    frame(16'h000F, 16'h0000, 32'hFFFF_FFFF, 64'h0);
    chk(32'({cmd_start_o, cmd_freeze_o, cmd_reset_o, cmd_ext_trip_o, par_wr_o}), 32'h0000_0000);
    chk(cyc_in_o[63:32], 32'h0000_0000);
    frame(16'hFFFF, 16'h0012, 32'h1234_5678, 64'h0004_0003_0002_0001);
    chk(32'({cmd_net_ctrl_o, cmd_ext_trip_o, cmd_reset_o, cmd_freeze_o, cmd_start_o}), 32'h0000_001F);
    chk(32'({par_wr_o, par_wr_num_o}), 32'h0001_0012);
    chk(par_wr_data_o, 32'h1234_5678);
    for (int g = 1; g < 5; g++) begin
      chk(cyc_in_o[32*g +: 32], {16'hA5A5, 16'(g)});
    end
    @(posedge clk_i);
    #1;
    chk(32'({par_wr_o, cyc_in_o[15:0]}), 32'h0000_0040);
    par_wr_narrow_i <= 1'b1;
    frame(16'h0010, 16'h0005, 32'hABCD_1234, 64'h0000_0000_0000_0009);
    chk(par_wr_data_o, 32'h0000_1234);
    chk(cyc_in_o[63:32], 32'hA5A5_0009);
    chk(cyc_in_o[95:64], 32'h0000_0000);
    par_wr_narrow_i <= 1'b0;
    for (int b = 0; b < 6; b++) begin
      st   <= 6'(1 << b);
      code <= 16'hBEEF;
      repeat (2) @(posedge clk_i);
      #1;
      chk(cyc_in_o[31:0], (b == 0 ? 32'hBEEF_0000 : 32'h0000_0000) | 32'(1 << b) | 32'h0000_0040);
    end
    st <= 6'h00;
    acc(1'b1, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_CMD, 32'h0000_0011, fbpdm_pkg::FBPDM_ANS_OK);
    acc(1'b0, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_CMD, 32'h0000_0000, fbpdm_pkg::FBPDM_ANS_OK);
    chk(exp_rdata_o, 32'h0000_0011);
    acc(1'b1, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_STATUS, 32'h0000_0001, fbpdm_pkg::FBPDM_ANS_READ_ONLY);
    acc(1'b0, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_SEL_VAL0, 32'h0000_0000, fbpdm_pkg::FBPDM_ANS_OK);
    chk(exp_rdata_o, 32'hA5A5_0009);
    acc(1'b1, fbpdm_pkg::EXP_CLASS, 8'h6D, 32'h0000_0001, fbpdm_pkg::FBPDM_ANS_READ_ONLY);
    acc(1'b0, 8'hA1, fbpdm_pkg::INST_CMD, 32'h0000_0000, fbpdm_pkg::FBPDM_ANS_BAD_PATH);
    acc(1'b0, fbpdm_pkg::EXP_CLASS, 8'h6E, 32'h0000_0000, fbpdm_pkg::FBPDM_ANS_BAD_PATH);
    acc(1'b1, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_WR_VAL, 32'h0000_0099, fbpdm_pkg::FBPDM_ANS_OK);
    acc(1'b1, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_WR_NUM, 32'h0000_0007, fbpdm_pkg::FBPDM_ANS_OK);
    @(posedge clk_i);
    #1;
    chk(32'({par_wr_o, par_wr_num_o}), 32'h0001_0007);
    chk(par_wr_data_o, 32'h0000_0099);
    acc(1'b0, fbpdm_pkg::EXP_CLASS, fbpdm_pkg::INST_STATUS, 32'h0000_0000, fbpdm_pkg::FBPDM_ANS_OK);
    chk(exp_rdata_o, 32'h0000_0040);
    results();
  end
endmodule : fbpdm_mapper_test
`default_nettype wire

/* File: verification/fbpdm_param_store.sv */
// parameter store model answering the four read slots
`timescale 1ns/1ns
`default_nettype none
module fbpdm_param_store (
  input  wire logic [63:0]  num_i,
  output var  logic [255:0] data_o
);
  // upper half never zero, so a missing truncation or zero-select shows
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      data_o[64*g +: 64] = {32'hFFFF_FFFF, 16'hA5A5, num_i[16*g +: 16]};
    end
  end
endmodule : fbpdm_param_store
`default_nettype wire
